// file: hw/position_zone_comparator.sv
// Position zone comparator: zone table, inside tests, zone ID and in-any-zone outputs.
// Holds the sixteen-entry table in a submodule and registers every pin-facing output.
// Assumes the position and write command come from logic on clk; outputs drive pin mapping.
// Assumes allocation levels are static configuration on the same clock.
`timescale 1ns/10ps
`default_nettype none
module position_zone_comparator (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic signed [pzc_pkg::POS_W-1:0] currentPosition,
  input wire logic memWrStrobe,
  input wire logic [pzc_pkg::ADDR_W-1:0] memWrAddr,
  input wire logic [1:0] memWrType,
  input wire logic [pzc_pkg::POS_W-1:0] memWrData,
  input wire logic zoneIdPinAllocation,
  input wire logic inZonePinAllocation,
  output logic zoneIdBit0Out,
  output logic zoneIdBit1Out,
  output logic zoneIdBit2Out,
  output logic zoneIdBit3Out,
  output logic inAnyZoneOut,
  output logic zoneIdOutEn,
  output logic inAnyZoneOutEn,
  output logic memWrDone,
  output logic [3:0] commandWarningCode
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // ID bits held apart so each pin is its own flop
  typedef struct packed {
    logic idBit0;
    logic idBit1;
    logic idBit2;
    logic idBit3;
    logic inZone;
    logic idEn;
    logic zoneEn;
    logic done;
    logic [3:0] warn;
  } pzc_state_t;

  pzc_state_t state_r;
  pzc_state_t state_nxt;

  // ----------------------------------------
  // Table and compare nets
  // ----------------------------------------
  logic [pzc_pkg::ZONE_COUNT*pzc_pkg::POS_W-1:0] negFlat;
  logic [pzc_pkg::ZONE_COUNT*pzc_pkg::POS_W-1:0] posFlat;
  logic [pzc_pkg::ZONE_COUNT-1:0] entryOn;
  logic [pzc_pkg::ZONE_COUNT-1:0] aboveLo;
  logic [pzc_pkg::ZONE_COUNT-1:0] belowHi;
  logic [pzc_pkg::ZONE_COUNT-1:0] hit;
  logic [(pzc_pkg::ZONE_COUNT+1)*pzc_pkg::ID_W-1:0] idChain;
  logic [pzc_pkg::ID_W-1:0] firstId;

  // ----------------------------------------
  // Write decode nets
  // ----------------------------------------
  logic [pzc_pkg::ADDR_W-1:0] relAddr;
  logic belowBase;
  logic pastEnd;
  logic aligned;
  logic longType;
  logic wrOk;
  logic wrNeg;
  logic [pzc_pkg::ID_W-1:0] wrIdx;
  logic [3:0] warnNxt;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign relAddr = memWrAddr - pzc_pkg::TABLE_BASE;
  assign belowBase = memWrAddr < pzc_pkg::TABLE_BASE;
  assign pastEnd = relAddr >= pzc_pkg::TABLE_BYTES;
  assign aligned = (memWrAddr & pzc_pkg::LONG_ALIGN_MASK) == 32'h00000000;
  assign longType = memWrType == pzc_pkg::TYPE_LONG;

  // Positive bound at the entry start, negative one long word up
  assign wrNeg = (relAddr & pzc_pkg::NEG_OFS) != 32'h00000000;
  assign wrIdx = relAddr[pzc_pkg::ENTRY_LSB +: pzc_pkg::ID_W];

  // Outside the table is another area: no write and no warning here
  always_comb begin
    wrOk = 1'b0;
    warnNxt = pzc_pkg::WARN_NONE;
    if (belowBase) begin
      wrOk = 1'b0;
      warnNxt = pzc_pkg::WARN_NONE;
    end else if (pastEnd) begin
      wrOk = 1'b0;
      warnNxt = pzc_pkg::WARN_NONE;
    end else if (!aligned) begin
      wrOk = 1'b0;
      warnNxt = pzc_pkg::WARN_BAD_ADDR;
    end else if (longType) begin
      wrOk = memWrStrobe;
      warnNxt = pzc_pkg::WARN_NONE;
    end else begin
      // Short and byte access dropped quietly, only long words fit a bound
      wrOk = 1'b0;
      warnNxt = pzc_pkg::WARN_NONE;
    end
  end

  // ----------------------------------------
  // Zone memory
  // ----------------------------------------
  pzc_zone_mem uMem (
    .clk(clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .wrEn(wrOk),
    .wrNeg(wrNeg),
    .wrIdx(wrIdx),
    .wrData(memWrData),
    .negFlat(negFlat),
    .posFlat(posFlat)
  );

  // ----------------------------------------
  // Inclusive compare per entry
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < pzc_pkg::ZONE_COUNT; g++) begin : gCmp
      logic signed [pzc_pkg::POS_W-1:0] lo;
      logic signed [pzc_pkg::POS_W-1:0] hi;

      assign lo = negFlat[g*pzc_pkg::POS_W +: pzc_pkg::POS_W];
      assign hi = posFlat[g*pzc_pkg::POS_W +: pzc_pkg::POS_W];

      assign entryOn[g] = (lo != pzc_pkg::BOUND_RESET) || (hi != pzc_pkg::BOUND_RESET);
      // Signed compare; an entry with lo above hi can never match
      assign aboveLo[g] = currentPosition >= lo;
      assign belowHi[g] = currentPosition <= hi;
      assign hit[g] = entryOn[g] && aboveLo[g] && belowHi[g];
    end
  endgenerate

  // ----------------------------------------
  // Lowest zone pick
  // ----------------------------------------
  // Empty end of the chain: no hit leaves the ID at zero
  assign idChain[pzc_pkg::ZONE_COUNT*pzc_pkg::ID_W +: pzc_pkg::ID_W] = '0;

  generate
    for (g = 0; g < pzc_pkg::ZONE_COUNT; g++) begin : gPick
      localparam int ENTRY = g;
      // Walks down from the top entry, so the lowest numbered hit wins
      assign idChain[g*pzc_pkg::ID_W +: pzc_pkg::ID_W] = hit[g] ? ENTRY[pzc_pkg::ID_W-1:0]
        : idChain[(g+1)*pzc_pkg::ID_W +: pzc_pkg::ID_W];
    end
  endgenerate

  assign firstId = idChain[0 +: pzc_pkg::ID_W];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.inZone = |hit;
    state_nxt.idBit0 = firstId[0];
    state_nxt.idBit1 = firstId[1];
    state_nxt.idBit2 = firstId[2];
    state_nxt.idBit3 = firstId[3];

    // Allocation only gates the pin drivers; the zone result runs on
    state_nxt.idEn = zoneIdPinAllocation;
    state_nxt.zoneEn = inZonePinAllocation;

    state_nxt.done = memWrStrobe;
    if (memWrStrobe) begin
      state_nxt.warn = warnNxt;
    end else begin
      state_nxt.warn = state_r.warn;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Cleared together with the table, so no output shows a zone after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '0;
    end else if (clkEn) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, each straight from its state flop
  // ----------------------------------------
  assign zoneIdBit0Out = state_r.idBit0;
  assign zoneIdBit1Out = state_r.idBit1;
  assign zoneIdBit2Out = state_r.idBit2;
  assign zoneIdBit3Out = state_r.idBit3;
  assign inAnyZoneOut = state_r.inZone;

  assign zoneIdOutEn = state_r.idEn;
  assign inAnyZoneOutEn = state_r.zoneEn;

  assign memWrDone = state_r.done;
  assign commandWarningCode = state_r.warn;
endmodule
`default_nettype wire

// file: hw/pzc_pkg.sv
// Package of the position zone comparator: table geometry, write command codes, reset values.
// Assumes position values and boundaries are 32-bit two's complement reference units.
package pzc_pkg;
  // ----------------------------------------
  // Table geometry
  // ----------------------------------------
  localparam int ZONE_COUNT = 16;
  localparam int ID_W = 4;
  localparam int POS_W = 32;
  localparam int ADDR_W = 32;
  // ----------------------------------------
  // Memory-write command
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] TABLE_BASE = 32'hF0040000;
  localparam logic [ADDR_W-1:0] TABLE_BYTES = 32'h00000080;
  localparam logic [ADDR_W-1:0] ENTRY_BYTES = 32'h00000008;
  localparam logic [ADDR_W-1:0] NEG_OFS = 32'h00000004;
  localparam logic [ADDR_W-1:0] LONG_ALIGN_MASK = 32'h00000003;
  localparam logic [1:0] TYPE_LONG = 2'h3;
  localparam int ENTRY_LSB = 3;
  localparam logic [3:0] WARN_NONE = 4'h0;
  localparam logic [3:0] WARN_BAD_ADDR = 4'h9;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [POS_W-1:0] BOUND_RESET = 32'h00000000;
endpackage

// file: hw/pzc_zone_mem.sv
// Zone boundary memory: sixteen entries of negative and positive boundary.
// Assumes one write port; all boundaries read in parallel for the comparators.
`timescale 1ns/10ps
`default_nettype none
module pzc_zone_mem (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic wrNeg,
  input wire logic [pzc_pkg::ID_W-1:0] wrIdx,
  input wire logic [pzc_pkg::POS_W-1:0] wrData,
  output logic [pzc_pkg::ZONE_COUNT*pzc_pkg::POS_W-1:0] negFlat,
  output logic [pzc_pkg::ZONE_COUNT*pzc_pkg::POS_W-1:0] posFlat
);
  // ----------------------------------------
  // Storage, one generate slot per entry
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < pzc_pkg::ZONE_COUNT; g++) begin : gEntry
      localparam int ENTRY = g;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          negFlat[g*pzc_pkg::POS_W +: pzc_pkg::POS_W] <= pzc_pkg::BOUND_RESET;
          posFlat[g*pzc_pkg::POS_W +: pzc_pkg::POS_W] <= pzc_pkg::BOUND_RESET;
        end else if (clkEn && wrEn && wrIdx == ENTRY[pzc_pkg::ID_W-1:0]) begin
          if (wrNeg) begin
            negFlat[g*pzc_pkg::POS_W +: pzc_pkg::POS_W] <= wrData;
          end else begin
            posFlat[g*pzc_pkg::POS_W +: pzc_pkg::POS_W] <= wrData;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: test/pzc_sva.sv
// Zone output and write answer checker.
// Assumes binding to the comparator top.
`timescale 1ns/10ps
`default_nettype none
module pzc_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic signed [31:0] currentPosition,
  input wire logic memWrStrobe,
  input wire logic [31:0] memWrAddr,
  input wire logic zoneIdBit0Out,
  input wire logic zoneIdBit1Out,
  input wire logic zoneIdBit2Out,
  input wire logic zoneIdBit3Out,
  input wire logic inAnyZoneOut,
  input wire logic memWrDone,
  input wire logic [3:0] commandWarningCode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic seen_r;
  wire logic [3:0] id = {zoneIdBit3Out, zoneIdBit2Out, zoneIdBit1Out, zoneIdBit0Out};
  wire logic inTbl = memWrAddr - pzc_pkg::TABLE_BASE < pzc_pkg::TABLE_BYTES;
  sequence wr; clkEn && memWrStrobe; endsequence
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) seen_r <= 1'b0;
    else if (clkEn && memWrStrobe) seen_r <= 1'b1;
  wr_done_a: assert property (wr |=> memWrDone) else $error("no done");
  warn_bad_a: assert property (wr ##0 (inTbl && memWrAddr[1:0] != 2'h0) |=> commandWarningCode == 4'h9)
    else $error("no warn");
  warn_ok_a: assert property (wr ##0 memWrAddr[1:0] == 2'h0 |=> commandWarningCode == 4'h0) else $error("warn");
  off_table_a: assert property (wr ##0 !inTbl |=> commandWarningCode == 4'h0) else $error("warn");
  id_off_a: assert property (!inAnyZoneOut |-> id == 4'h0) else $error("id on");
  empty_id_a: assert property (!seen_r |-> id == 4'h0) else $error("id on");
  empty_zone_a: assert property (!seen_r |-> !inAnyZoneOut) else $error("zone on");
  quiet_hold_a: assert property ((clkEn && !memWrStrobe && $stable(currentPosition)) [*2] |=>
    $stable({id, inAnyZoneOut})) else $error("drift");
endmodule
`default_nettype wire

// file: test/pzc_pin_sink.sv
// Pin sense model of the outside controller.
// Assumes pulled-down inputs where a pin is undriven.
`timescale 1ns/10ps
`default_nettype none
module pzc_pin_sink (
  input wire logic idEn,
  input wire logic zoneEn,
  input wire logic [3:0] idOut,
  input wire logic zoneOut,
  output logic [4:0] sensed
);
  assign sensed = {zoneEn & zoneOut, idOut & {4{idEn}}};
endmodule
`default_nettype wire

// file: test/tb.sv
// Bench of the zone comparator with a reference table.
// Assumes the package compiles first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if (g !== e) begin bad_count++; $display("[ERR] %0t %h %h", $time, g, e); end end
module tb;
  localparam logic [31:0] B = pzc_pkg::TABLE_BASE;
  logic clk = 0, reset_n = 0, en = 1, st = 0, za = 1, ia = 1;
  logic signed [31:0] p = 0, nb [16] = '{default: 0}, pb [16] = '{default: 0};
  logic [31:0] a = 0, d = 0;
  logic [1:0] t = 3;
  logic [3:0] w = 0;
  logic [9:0] ex = 0, want, q [$];
  wire logic [3:0] ids, code;
  wire logic [4:0] sensed;
  wire logic idEn, zEn, done, inZ;
  int bad_count = 0, tests_run = 0, zn [5] = '{1, 2, 4, 8, 0}, ra [5] = '{2, 128, 129, 8, 12};
  int zl [5] = '{-1000, 99000, 199000, 299000, -5}, zh [5] = '{1000, 101000, 201000, 301000, 5};
  int pl [7] = '{-1001, -1000, 5, 6, 1001, 101000, 301001};
  always #12.5 clk = ~clk;
  position_zone_comparator dut (.clk, .reset_n, .clkEn(en), .currentPosition(p), .memWrStrobe(st), .memWrAddr(a),
    .memWrType(t), .memWrData(d), .zoneIdPinAllocation(za), .inZonePinAllocation(ia), .zoneIdBit0Out(ids[0]),
    .zoneIdBit1Out(ids[1]), .zoneIdBit2Out(ids[2]), .zoneIdBit3Out(ids[3]), .inAnyZoneOut(inZ),
    .zoneIdOutEn(idEn), .inAnyZoneOutEn(zEn), .memWrDone(done), .commandWarningCode(code));
  pzc_pin_sink sink (.idEn, .zoneEn(zEn), .idOut(ids), .zoneOut(inZ), .sensed);
  task automatic cyc(input logic [2:0] m, input logic s, input logic [31:0] ad, input logic [1:0] ty,
    input logic [31:0] dv, input logic signed [31:0] pv);
    logic [4:0] h;
    logic it;
    @(negedge clk);
    {en, za, ia, st, a, t, d, p} = {m, s, ad, ty, dv, pv};
    h = 5'h10;
    it = ad - B < pzc_pkg::TABLE_BYTES;
    for (int i = 15; i >= 0; i--) if ((nb[i] != 0 || pb[i] != 0) && pv >= nb[i] && pv <= pb[i]) h = 5'(i);
    if (m[2] && s) w = (it && ad[1:0] != 0) ? 4'h9 : 4'h0;
    if (m[2]) ex = {s, w, m[0] && h < 16, m[1] ? h[3:0] : 4'h0};
    if (m[2] && s && ty == 3 && it && ad[1:0] == 0) begin
      if (ad[2]) nb[ad[6:3]] = dv;
      else pb[ad[6:3]] = dv;
    end
    q.push_back(ex);
  endtask
  always @(posedge clk) begin
    #1;
    if (q.size() > 0) begin
      want = q.pop_front();
      `CHK({done, code, sensed}, want)
    end
  end
  task automatic give_verdict;
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hC31DE500));
    repeat (8) @(negedge clk);
    reset_n = 1;
    repeat (2) cyc(7, 0, 0, 3, 0, 0);
    foreach (zn[i]) begin
      cyc(7, 1, B + 8 * zn[i], 3, zh[i], 0);
      cyc(7, 1, B + 8 * zn[i] + 4, 3, zl[i], 0);
    end
    foreach (pl[i]) repeat (3) cyc(7, 0, 0, 3, 0, pl[i]);
    foreach (ra[i]) cyc(7, 1, B + ra[i], i < 3 ? 3 : 5 - i, 7, 1000);
    repeat (400) cyc({$urandom % 8 > 0, $urandom % 4 > 0, $urandom % 4 > 0}, $urandom, B + $urandom % 132,
      $urandom % 2 ? 3 : $urandom, $urandom % 800000 - 400000, $urandom % 800000 - 400000);
    repeat (2) @(posedge clk);
    #2 give_verdict();
  end
endmodule
bind position_zone_comparator pzc_sva chk (.clk, .reset_n, .clkEn, .currentPosition, .memWrStrobe, .memWrAddr,
  .zoneIdBit0Out, .zoneIdBit1Out, .zoneIdBit2Out, .zoneIdBit3Out, .inAnyZoneOut, .memWrDone, .commandWarningCode);
`default_nettype wire
